// >>> hdl/smbta_pkg.sv
// Purpose: Shared constants and carriers for the SMBus target access port
// Assumes: 250 MHz core clock
// Notes:   Field slots hold the address and data bytes in bus order
package smbta_pkg;
    // Target address; arbitrary default
    localparam logic [6:0] SMBTA_DEV_ADDR = 7'h30;
    // Command byte layout
    localparam int CMD_BEGIN = 7;
    localparam int CMD_END   = 6;
    localparam int CMD_MODE  = 5;
    localparam int CMD_OP_LO = 2;
    localparam logic [1:0] SIZE_BYTE  = 2'h0;
    localparam logic [1:0] SIZE_WORD  = 2'h1;
    localparam logic [1:0] SIZE_BLOCK = 2'h2;
    localparam logic [1:0] OP_READ     = 2'h0;
    localparam logic [1:0] OP_WR_BYTE  = 2'h1;
    localparam logic [1:0] OP_WR_WORD  = 2'h2;
    localparam logic [1:0] OP_WR_DWORD = 2'h3;
    // Memory-mapped region codes
    localparam logic [7:0] REGION_DMA  = 8'h01;
    localparam logic [7:0] REGION_DRAM = 8'h08;
    localparam logic [7:0] REGION_AUX  = 8'h09;
    // Field slots
    localparam logic [2:0] FLD_BUS  = 3'h0;
    localparam logic [2:0] FLD_DEVF = 3'h1;
    localparam logic [2:0] FLD_OFFH = 3'h2;
    localparam logic [2:0] FLD_OFFL = 3'h3;
    localparam logic [2:0] FLD_D3   = 3'h4;
    localparam logic [2:0] FLD_D2   = 3'h5;
    localparam logic [2:0] FLD_D1   = 3'h6;
    localparam logic [2:0] FLD_D0   = 3'h7;
    localparam logic [7:0] FIELD_RST = 8'h00;
    // Status byte layout
    localparam int STATUS_TMO    = 7;
    localparam int STATUS_MABORT = 5;
    localparam int STATUS_TABORT = 4;
    localparam int STATUS_OK     = 0;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // Read-out slots: 1 status, 2..5 data; count is slots left from 6
    localparam logic [2:0] RD_FIRST = 3'h1;
    localparam logic [2:0] RD_END   = 3'h6;
    // Internal completion limit
    localparam int TIMEOUT_US     = 2000;
    localparam int CLK_MHZ        = 250;
    localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
    localparam int FIFO_WORDS     = 8;

    typedef struct packed {
        logic        mode;
        logic [1:0]  op;
        logic [7:0]  sel;
        logic [7:0]  devfn;
        logic [11:0] offset;
        logic [31:0] data;
        logic [3:0]  be;
    } smbta_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic        master_abort;
        logic        target_abort;
    } smbta_rsp_t;
endpackage

// >>> hdl/smbta_target.sv
// Purpose: SMBus target that turns field sequences into internal accesses
// Assumes: SCL and SDA are open-drain pins sampled on clk
// Notes:   Requests pass an 8-word FIFO; the bus is stretched until done
// Operation
// - Byte count gives bytes that follow
// - Read count includes status byte
// - Byte count only in block transfers
// - Config mode ignores bus bits 7:5
// - Region codes 01h, 08h, 09h only
// - No busy bit; stretch clock instead
// - Bus byte passed through for internal use
// - Offset high nibble from byte 1
// - Offset low byte from byte 0
// - Reads return whole aligned doubleword
// - Writes use only bytes of size
// - Status byte precedes read data
// - Status bit 7 marks timeout
// - Bits 5, 4 report aborts
// - Status bit 0 marks success
// - Command bits 7, 6 mark first, last
// - Command bit 5 selects access mode
// - NACK new transfers while command busy
`timescale 1ns/1ps

module smbta_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp;
    logic [AW:0]      rp;
    wire              full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    wire              empty = (wp == rp);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rp[AW-1:0]];
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid && !full) begin
                wp <= wp + 1'b1;
            end
            if (out_ready && !empty) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule

module smbta_target
    import smbta_pkg::*;
#(
    parameter int         TIMEOUT_CYC = TIMEOUT_CYCLES,
    parameter int         FIFO_DEPTH  = FIFO_WORDS,
    parameter logic [6:0] DEV_ADDR    = SMBTA_DEV_ADDR
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             req_valid,
    output smbta_req_t       req,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    input  wire smbta_rsp_t  rsp
);
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_HOLD, ST_ACK, ST_TX, ST_RACK, ST_IGNORE} smbta_st_t;

    function automatic logic [7:0] exp_len(input logic [1:0] size);
        case (size)
            SIZE_BYTE: exp_len = 8'h01;
            SIZE_WORD: exp_len = 8'h02;
            default:   exp_len = 8'h04;
        endcase
    endfunction

    function automatic logic [3:0] be_of(input logic [1:0] op);
        case (op)
            OP_WR_BYTE: be_of = 4'h1;
            OP_WR_WORD: be_of = 4'h3;
            default:    be_of = 4'hF;
        endcase
    endfunction

    function automatic logic [7:0] mk_status(input logic tmo, input logic ma,
                                             input logic ta, input logic ok);
        logic [7:0] s;
        s = STATUS_RST;
        s[STATUS_TMO]    = tmo;
        s[STATUS_MABORT] = ma;
        s[STATUS_TABORT] = ta;
        s[STATUS_OK]     = ok;
        mk_status = s;
    endfunction

    smbta_st_t   state;
    logic        scl_s1, scl_s2, scl_d;
    logic        sda_s1, sda_s2, sda_d;
    logic [7:0]  shreg;
    logic [3:0]  bitcnt;
    logic [7:0]  fields [8];
    logic [7:0]  cmd;
    logic [7:0]  payload_length;
    logic [7:0]  wr_left;
    logic [2:0]  wr_ptr;
    logic [2:0]  rd_idx;
    logic        first_byte, cmd_phase, len_phase, rd_mode, send_cnt;
    logic [7:0]  read_status_byte;
    logic        issue, pending, outstanding;
    logic [31:0] hold_cnt;
    smbta_req_t  next_req;
    logic        fifo_in_ready, fifo_out_valid;
    smbta_req_t  fifo_out_data;

    // Pin sampling and bus conditions
    wire scl_rise   = scl_s2 && !scl_d;
    wire scl_fall   = !scl_s2 && scl_d;
    wire start_cond = scl_s2 && scl_d && sda_d && !sda_s2 && state != ST_HOLD;
    wire stop_cond  = scl_s2 && scl_d && !sda_d && sda_s2 && state != ST_HOLD;

    // Received-byte decode
    wire byte_done = state == ST_RX && scl_fall && bitcnt == 4'h8;
    wire rx_addr   = byte_done && first_byte;
    wire rx_cmd    = byte_done && !first_byte && cmd_phase;
    wire rx_len    = byte_done && !first_byte && !cmd_phase && len_phase;
    wire rx_pay    = byte_done && !first_byte && !cmd_phase && !len_phase;
    wire ack_addr  = shreg[7:1] == DEV_ADDR && !outstanding && !issue;
    wire ack_pay   = wr_left != 8'h00;
    wire fire      = rx_pay && wr_left == 8'h01 && cmd[CMD_END];
    wire rx_ack    = rx_addr ? ack_addr : (rx_pay ? ack_pay : 1'b1);
    wire tx_load   = state == ST_ACK && scl_fall && rd_mode;

    // Request assembly from the field slots
    wire cfg_mode   = cmd[CMD_MODE];
    wire [1:0] op   = cmd[CMD_OP_LO+1:CMD_OP_LO];
    wire [3:0] be   = be_of(op);
    wire [31:0] wdata = {fields[FLD_D3], fields[FLD_D2], fields[FLD_D1], fields[FLD_D0]};
    wire [31:0] mask  = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    wire [7:0] bus_sel = cfg_mode ? {3'h0, fields[FLD_BUS][4:0]} : fields[FLD_BUS];
    wire region_ok = cfg_mode || fields[FLD_BUS] == REGION_DMA
                     || fields[FLD_BUS] == REGION_DRAM || fields[FLD_BUS] == REGION_AUX;
    assign next_req.mode   = cfg_mode;
    assign next_req.op     = op;
    assign next_req.sel    = bus_sel;
    assign next_req.devfn  = fields[FLD_DEVF];
    assign next_req.offset = {fields[FLD_OFFH][3:0], fields[FLD_OFFL]};
    assign next_req.data   = wdata & mask;
    assign next_req.be     = be;

    // Completion of the stretched access
    wire tmo_hit    = state == ST_HOLD && hold_cnt == 32'(TIMEOUT_CYC - 1);
    wire rsp_ok_now = pending && rsp_valid;
    wire reject     = issue && !region_ok;
    wire push       = issue && region_ok && fifo_in_ready && !tmo_hit;
    wire done_now   = state == ST_HOLD && (rsp_ok_now || tmo_hit || reject);

    // Byte sent on the next read slot
    wire [7:0] rd_byte = rd_idx == RD_FIRST ? read_status_byte :
                         rd_idx == 3'h2 ? fields[FLD_D3] :
                         rd_idx == 3'h3 ? fields[FLD_D2] :
                         rd_idx == 3'h4 ? fields[FLD_D1] :
                         rd_idx == 3'h5 ? fields[FLD_D0] : 8'hFF;
    wire [7:0] tx_byte = send_cnt ? {5'h00, RD_END - rd_idx} : rd_byte;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
        end
    end

    // Bit engine
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state  <= ST_IDLE;
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else if (start_cond) begin
            state  <= ST_RX;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise && bitcnt != 4'h8) begin
                        shreg  <= {shreg[6:0], sda_s2};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (byte_done) begin
                        if (fire) begin
                            state  <= ST_HOLD;
                            scl_oe <= 1'b1;
                        end else if (rx_ack) begin
                            state  <= ST_ACK;
                            sda_oe <= 1'b1;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_HOLD: begin
                    if (done_now) begin
                        state  <= ST_ACK;
                        sda_oe <= 1'b1;
                        scl_oe <= 1'b0;
                    end
                end
                ST_ACK: begin
                    if (scl_fall && rd_mode) begin
                        state  <= ST_TX;
                        sda_oe <= !tx_byte[7];
                        shreg  <= {tx_byte[6:0], 1'b0};
                        bitcnt <= 4'h1;
                    end else if (scl_fall) begin
                        state  <= ST_RX;
                        sda_oe <= 1'b0;
                        bitcnt <= 4'h0;
                    end
                end
                ST_TX: begin
                    if (scl_fall && bitcnt == 4'h8) begin
                        state  <= ST_RACK;
                        sda_oe <= 1'b0;
                    end else if (scl_fall) begin
                        sda_oe <= !shreg[7];
                        shreg  <= {shreg[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        state <= sda_s2 ? ST_IGNORE : ST_ACK;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Transaction bookkeeping and field slots
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < 8; i++) begin
                fields[i] <= FIELD_RST;
            end
            cmd            <= 8'h00;
            payload_length <= 8'h00;
            wr_left        <= 8'h00;
            wr_ptr         <= 3'h0;
            rd_idx         <= RD_FIRST;
            first_byte     <= 1'b0;
            cmd_phase      <= 1'b0;
            len_phase      <= 1'b0;
            rd_mode        <= 1'b0;
            send_cnt       <= 1'b0;
        end else begin
            if (start_cond) begin
                first_byte <= 1'b1;
                cmd_phase  <= 1'b0;
                len_phase  <= 1'b0;
                rd_mode    <= 1'b0;
            end
            if (rx_addr) begin
                first_byte <= 1'b0;
                rd_mode    <= ack_addr && shreg[0];
                cmd_phase  <= ack_addr && !shreg[0];
                send_cnt   <= ack_addr && shreg[0] && cmd[1:0] == SIZE_BLOCK;
            end
            if (rx_cmd) begin
                cmd       <= shreg;
                cmd_phase <= 1'b0;
                len_phase <= shreg[1:0] == SIZE_BLOCK;
                wr_left   <= shreg[1:0] == SIZE_BLOCK ? 8'h00 : exp_len(shreg[1:0]);
                if (shreg[CMD_BEGIN]) begin
                    wr_ptr <= 3'h0;
                    rd_idx <= RD_FIRST;
                end
            end
            if (rx_len) begin
                payload_length <= shreg;
                wr_left        <= shreg;
                len_phase      <= 1'b0;
            end
            if (rx_pay && ack_pay) begin
                fields[wr_ptr] <= shreg;
                wr_ptr         <= wr_ptr + 3'h1;
                wr_left        <= wr_left - 8'h01;
            end
            if (tx_load && send_cnt) begin
                send_cnt <= 1'b0;
            end else if (tx_load && rd_idx != RD_END) begin
                rd_idx <= rd_idx + 3'h1;
            end
            if (rsp_ok_now && op == OP_READ) begin
                {fields[FLD_D3], fields[FLD_D2], fields[FLD_D1], fields[FLD_D0]} <= rsp.data;
            end
        end
    end

    // Internal access tracking and status
    always_ff @(posedge clk) begin
        if (!nrst) begin
            issue            <= 1'b0;
            pending          <= 1'b0;
            outstanding      <= 1'b0;
            hold_cnt         <= 32'h0;
            read_status_byte <= STATUS_RST;
        end else begin
            hold_cnt <= state == ST_HOLD ? hold_cnt + 32'h1 : 32'h0;
            if (fire) begin
                issue <= 1'b1;
            end else if (push || reject || tmo_hit) begin
                issue <= 1'b0;
            end
            if (push) begin
                pending     <= 1'b1;
                outstanding <= 1'b1;
            end else begin
                if (rsp_ok_now || tmo_hit) begin
                    pending <= 1'b0;
                end
                if (rsp_valid) begin
                    outstanding <= 1'b0;
                end
            end
            if (rsp_ok_now) begin
                read_status_byte <= mk_status(1'b0, rsp.master_abort, rsp.target_abort,
                                              !(rsp.master_abort || rsp.target_abort));
            end else if (tmo_hit) begin
                read_status_byte <= mk_status(1'b1, 1'b0, 1'b0, 1'b0);
            end else if (reject) begin
                read_status_byte <= mk_status(1'b0, 1'b1, 1'b0, 1'b0);
            end
        end
    end

    wire fifo_out_ready = !req_valid || req_ready;

    smbta_fifo #(.WIDTH($bits(smbta_req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (next_req),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_valid <= 1'b0;
            req       <= '0;
            scl_out   <= 1'b0;
            sda_out   <= 1'b0;
        end else if (fifo_out_ready) begin
            req_valid <= fifo_out_valid;
            req       <= fifo_out_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_stretch;
        fire |=> scl_oe && state == ST_HOLD;
    endproperty
    a_stretch: assert property (p_stretch) else $error("final byte not stretched");

    property p_release;
        done_now |=> !scl_oe && sda_oe && state == ST_ACK;
    endproperty
    a_release: assert property (p_release) else $error("stretch not released");

    property p_busy_nack;
        rx_addr && outstanding |=> state == ST_IGNORE && !sda_oe;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("busy address acked");

    property p_timeout;
        tmo_hit && !rsp_ok_now |=> read_status_byte[STATUS_TMO] && !scl_oe;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not flagged");

    property p_abort;
        rsp_ok_now && rsp.master_abort |=> read_status_byte[STATUS_MABORT]
            && !read_status_byte[STATUS_OK];
    endproperty
    a_abort: assert property (p_abort) else $error("master abort lost");

    property p_success;
        rsp_ok_now && !rsp.master_abort && !rsp.target_abort |=> read_status_byte[STATUS_OK];
    endproperty
    a_success: assert property (p_success) else $error("success not flagged");

    property p_byte_mask;
        push && next_req.op == OP_WR_BYTE |-> next_req.be == 4'h1 && next_req.data[31:8] == 24'h0;
    endproperty
    a_byte_mask: assert property (p_byte_mask) else $error("byte write not masked");

    property p_cfg_bus;
        push && next_req.mode |-> next_req.sel[7:5] == 3'h0;
    endproperty
    a_cfg_bus: assert property (p_cfg_bus) else $error("bus bits 7:5 leaked");

    property p_read_fill;
        rsp_ok_now && op == OP_READ |=> {fields[FLD_D3], fields[FLD_D0]} ==
                                        {$past(rsp.data[31:24]), $past(rsp.data[7:0])};
    endproperty
    a_read_fill: assert property (p_read_fill) else $error("read data not stored");

    property p_count;
        tx_load && send_cnt && rd_idx == RD_FIRST |=> state == ST_TX && sda_oe && shreg == 8'h0A;
    endproperty
    a_count: assert property (p_count) else $error("bad read byte count");

    property p_status_first;
        tx_load && !send_cnt && rd_idx == RD_FIRST |=> state == ST_TX
            && shreg == {$past(read_status_byte[6:0]), 1'b0}
            && sda_oe == !$past(read_status_byte[7]);
    endproperty
    a_status_first: assert property (p_status_first) else $error("status not first");
endmodule

// >>> bench/smbta_host.sv
// Purpose: SMBus host model driving open-drain SCL and SDA
// Assumes: pull-ups on both lines; bit time 80 ns
// Notes:   Waits on SCL high so the target may stretch
`timescale 1ns/1ps
module smbta_host (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic put_bit(input logic b);
        #10 sda_low = ~b;
        #30 scl_low = 1'b0;
        wait (scl);
        #40 scl_low = 1'b1;
    endtask
    task automatic get_bit(output logic b);
        #10 sda_low = 1'b0;
        #30 scl_low = 1'b0;
        wait (scl);
        #20 b = sda;
        #20 scl_low = 1'b1;
    endtask
    task automatic start();
        sda_low = 1'b0;
        #20 scl_low = 1'b0;
        wait (scl);
        #20 sda_low = 1'b1;
        #20 scl_low = 1'b1;
    endtask
    task automatic stop();
        #10 sda_low = 1'b1;
        #30 scl_low = 1'b0;
        wait (scl);
        #20 sda_low = 1'b0;
        #20;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ack = ~a;
    endtask
    task automatic rd_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule

// >>> bench/smbta_target_test.sv
// Purpose: Self-checking bench for the SMBus target access port
// Assumes: host model on the link, bench answers internal requests
// Notes:   Timeout shortened to 200 cycles
`timescale 1ns/1ps
module smbta_target_test;
    import smbta_pkg::*;
    localparam int TMO = 200;
    logic       clk, nrst, req_ready, rsp_valid, req_valid, ack, ma, ta;
    logic       scl_oe, sda_oe, scl_out, sda_out, h_scl, h_sda;
    logic [31:0] rdata;
    smbta_req_t req, got;
    smbta_rsp_t rsp;
    int         lat, nreq, wcnt, cyc, err_total, checks_done;
    logic [7:0] pl[$];
    logic [7:0] rb[6];
    logic [7:0] ex[6];
    wire logic  scl = ~(scl_oe & ~scl_out | h_scl);
    wire logic  sda = ~(sda_oe & ~sda_out | h_sda);
    assign rsp = {rdata, ma, ta};
    smbta_target #(.TIMEOUT_CYC(TMO)) smbta_target_i (.clk(clk), .nrst(nrst),
        .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));
    smbta_host smbta_host_i (.scl(scl), .sda(sda), .scl_low(h_scl), .sda_low(h_sda));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Internal side: ready toggles, answer after lat cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        req_ready <= nrst && !req_ready;
        rsp_valid <= 1'b0;
        if (!nrst) begin
            nreq <= 0;
            wcnt <= 0;
        end else if (req_valid && req_ready) begin
            got <= req;
            nreq <= nreq + 1;
            wcnt <= lat;
        end else if (wcnt == 1) begin
            rsp_valid <= 1'b1;
            wcnt <= 0;
        end else if (wcnt > 1) begin
            wcnt <= wcnt - 1;
        end
        if (cyc == 60000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [66:0] g, input logic [66:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] cmd);
        logic a;
        smbta_host_i.start();
        smbta_host_i.wr_byte(8'h60, a);
        ack = a;
        smbta_host_i.wr_byte(cmd, a);
        ack &= a;
        foreach (pl[i]) begin
            smbta_host_i.wr_byte(pl[i], a);
            ack &= a;
        end
        smbta_host_i.stop();
    endtask
    task automatic rd(input logic [7:0] cmd, input int n);
        logic a;
        smbta_host_i.start();
        smbta_host_i.wr_byte(8'h60, a);
        smbta_host_i.wr_byte(cmd, a);
        smbta_host_i.start();
        smbta_host_i.wr_byte(8'h61, a);
        for (int i = 0; i < n; i++) smbta_host_i.rd_byte(rb[i], i == n - 1);
        smbta_host_i.stop();
    endtask
    task automatic finish_test();
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        rdata = 32'h0;
        ma = 1'b0;
        ta = 1'b0;
        lat = 30;
        err_total = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        pl = '{8'h08, 8'hE0, 8'h18, 8'hF3, 8'h44, 8'h11, 8'h22, 8'h33, 8'h44};
        wr(8'hEE);
        chk(ack, 1'b1);
        chk(got, {1'b1, OP_WR_DWORD, 8'h00, 8'h18, 12'h344, 32'h11223344, 4'hF});
        @(posedge clk) rdata <= 32'hA5C30F96;
        pl = '{8'h04, 8'h08, 8'h00, 8'h01, 8'h20};
        wr(8'hC2);
        chk({got.mode, got.op, got.sel, got.offset, got.be}, {3'h0, 8'h08, 12'h120, 4'hF});
        rd(8'h82, 6);
        ex = '{8'h05, 8'h01, 8'hA5, 8'hC3, 8'h0F, 8'h96};
        for (int i = 0; i < 6; i++) chk(rb[i], ex[i]);
        pl = '{8'h09, 8'h00, 8'h00, 8'h08};
        wr(8'h8B);
        pl = '{8'h12, 8'h34, 8'hBE, 8'hEF};
        wr(8'h4B);
        chk(got, {1'b0, OP_WR_WORD, 8'h09, 8'h00, 12'h008, 32'h0000BEEF, 4'h3});
        pl = '{8'h08, 8'h08, 8'h00, 8'h0F, 8'hFC, 8'hAA, 8'hBB, 8'hCC, 8'hDD};
        wr(8'hC6);
        chk(got, {1'b0, OP_WR_BYTE, 8'h08, 8'h00, 12'hFFC, 32'h000000DD, 4'h1});
        rd(8'h81, 2);
        chk({rb[0], rb[1]}, {8'h01, 8'hAA});
        pl = '{8'h04, 8'h05, 8'h00, 8'h00, 8'h00};
        wr(8'hC2);
        rd(8'h82, 2);
        chk(rb[1], 8'h20);
        chk(nreq, 4);
        pl = '{8'h04, 8'h01, 8'h00, 8'h00, 8'h10};
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) {ma, ta} <= k ? 2'b01 : 2'b10;
            wr(8'hC2);
            rd(8'h82, 2);
            chk(rb[1], k ? 8'h10 : 8'h20);
        end
        @(posedge clk) {ma, ta} <= 2'b00;
        lat = 900;
        wr(8'hC2);
        pl = {};
        wr(8'h82);
        chk(ack, 1'b0);
        wait (wcnt == 0);
        repeat (4) @(posedge clk);
        rd(8'h82, 2);
        chk(rb[1], 8'h80);
        finish_test();
    end
endmodule
